//--- common/lftr_pkg.sv
// Constants for the local-temperature fan ramp limiter
`default_nettype none
package lftr_pkg;
    // Register offsets
    localparam logic [7:0] ADDR_CFG6   = 8'h10;
    localparam logic [7:0] ADDR_CFG1   = 8'h40;
    localparam logic [7:0] ADDR_ACOU2  = 8'h63;
    localparam logic [7:0] ADDR_DUTY   = 8'h65;
    // Reset values
    localparam logic [7:0] RST_ACOU2   = 8'h00;
    localparam logic [7:0] RST_CFG6    = 8'h00;
    localparam logic [7:0] RST_CFG1    = 8'h00;
    localparam logic [7:0] RST_DUTY    = 8'h00;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;
    // Field positions
    localparam int unsigned CFG6_SLOW_BIT   = 7;
    localparam int unsigned CFG6_LOCAL_BIT  = 2;
    localparam int unsigned CFG1_LOCK_BIT   = 1;
    localparam int unsigned CODE_LSB        = 0;
    localparam int unsigned CODE_MSB        = 2;
    // Slot increment per ramp code, code 0 first
    localparam logic [7:0] RAMP_INC [8] = '{8'h01, 8'h02, 8'h03, 8'h04,
                                            8'h08, 8'h0C, 8'h18, 8'h30};
    // Timing
    localparam real CLK_HZ           = 40.0e6;
    localparam real RAMP_FAST_S      = 37.5;
    localparam real RAMP_SLOW_S      = 52.2;
    localparam real DUTY_STEPS       = 255.0;
    localparam int unsigned SLOWDOWN = 4;
    // One slot: full ramp at increment 1 over 255 duty steps, rounded down
    localparam int unsigned SLOT_FAST_CYC = $rtoi(RAMP_FAST_S * CLK_HZ / DUTY_STEPS);
    localparam int unsigned SLOT_SLOW_CYC = $rtoi(RAMP_SLOW_S * CLK_HZ / DUTY_STEPS);
    localparam int unsigned PER_W = 32;
endpackage : lftr_pkg
`default_nettype wire

//--- common/lftr_slot_if.sv
// Slot timer link between the ramp controller and its timer
`timescale 1ns/100ps
`default_nettype none
interface lftr_slot_if;
    logic [31:0] period;
    logic        tick;
    modport ctrl  (output period, input tick);
    modport timer (input period, output tick);
endinterface : lftr_slot_if
`default_nettype wire

//--- hw/lftr_slot_timer.sv
// Free-running time slot generator
`timescale 1ns/100ps
`default_nettype none
module lftr_slot_timer
(
    input  wire logic       sys_clk_i,  // System clock
    input  wire logic       rst_i,      // Sync reset, high
    lftr_slot_if.timer      slot        // Period in, tick out
);
    logic [31:0] cnt_r;

    // Compare with >= so a shortened period takes effect at once
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            cnt_r     <= '0;
            slot.tick <= 1'b0;
        end
        else if (cnt_r >= slot.period - 32'h00000001)
        begin
            cnt_r     <= '0;
            slot.tick <= 1'b1;
        end
        else
        begin
            cnt_r     <= cnt_r + 32'h00000001;
            slot.tick <= 1'b0;
        end
    end

    a_tick_spacing : assert property (@(posedge sys_clk_i) disable iff (rst_i)
        slot.tick |=> !slot.tick)
        else $error("slot tick lasted more than one cycle");
endmodule // lftr_slot_timer
`default_nettype wire

//--- hw/lftr_top.sv
// Ramp limiter for the fan drive duty under local-temperature control
//
// Summary of operation
// - Once the lock bit is set, writes to the ramp register are ignored.
// - A set local slowdown bit in config six makes each slot four times longer.
// - Bits [2:0] of the ramp register limit local-driven duty changes.
// - Global slow bit clear: full ramp takes 37.5 s down to 0.8 s.
// - Global slow bit set: full ramp takes longer, 52.2 s at code 0.
// - Ramp register resets to 0x00 and is writable until locked.
`timescale 1ns/100ps
`default_nettype none
module lftr_top
#(
    parameter int unsigned SLOT_FAST_CYC = lftr_pkg::SLOT_FAST_CYC, // Slot, slow bit clear
    parameter int unsigned SLOT_SLOW_CYC = lftr_pkg::SLOT_SLOW_CYC  // Slot, slow bit set
)
(
    input  wire logic       sys_clk_i,           // System clock, 40 MHz
    input  wire logic       rst_i,               // Sync reset, high
    input  wire logic [7:0] addr_i,              // Register address
    input  wire logic [7:0] wr_data_i,           // Write data
    input  wire logic       wr_i,                // Write strobe
    input  wire logic       rd_i,                // Read strobe
    output logic      [7:0] rd_data_o,           // Read data, cycle after strobe
    input  wire logic       local_ctrl_i,        // Local channel drives the fan
    input  wire logic [7:0] target_duty_i,       // Target duty from the loop
    output logic      [7:0] fan_drive_output_o   // Limited fan duty
);

    lftr_slot_if slot ();

    logic [7:0] acou_r;
    logic [7:0] cfg6_r;
    logic [7:0] cfg1_r;
    logic [7:0] duty_r;
    logic [7:0] duty_nxt;
    logic [7:0] rdata_r;
    logic [7:0] inc;
    logic [2:0] code;
    logic       locked;
    logic       wr_acou;
    logic       wr_cfg6;
    logic       wr_cfg1;
    logic       slow_sel;
    logic       quad_sel;
    logic [31:0] base_per;

    function automatic logic [7:0] code_to_inc(input logic [2:0] c);
        code_to_inc = lftr_pkg::RAMP_INC[c];
    endfunction

    // Step cur toward tgt by no more than step, landing exactly on tgt
    function automatic logic [7:0] step_toward(input logic [7:0] cur,
                                               input logic [7:0] tgt,
                                               input logic [7:0] step);
        logic [7:0] gap;
        gap = 8'h00;
        if (tgt > cur)
        begin
            gap = tgt - cur;
            step_toward = (gap <= step) ? tgt : cur + step;
        end
        else
        begin
            gap = cur - tgt;
            step_toward = (gap <= step) ? tgt : cur - step;
        end
    endfunction

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        hit = (a == b);
    endfunction

    assign locked  = cfg1_r[lftr_pkg::CFG1_LOCK_BIT];
    assign wr_acou = wr_i && hit(addr_i, lftr_pkg::ADDR_ACOU2) && !locked;
    assign wr_cfg6 = wr_i && hit(addr_i, lftr_pkg::ADDR_CFG6) && !locked;
    assign wr_cfg1 = wr_i && hit(addr_i, lftr_pkg::ADDR_CFG1) && !locked;

    // Ramp register
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
            acou_r <= lftr_pkg::RST_ACOU2;
        else if (wr_acou)
            acou_r <= wr_data_i;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
            cfg6_r <= lftr_pkg::RST_CFG6;
        else if (wr_cfg6)
            cfg6_r <= wr_data_i;
    end

    // Lock is sticky: once set only reset clears it
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
            cfg1_r <= lftr_pkg::RST_CFG1;
        else if (wr_cfg1)
            cfg1_r <= wr_data_i;
    end

    // Registered read port; unmapped reads return zero
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
            rdata_r <= lftr_pkg::RD_UNMAPPED;
        else if (rd_i)
        begin
            unique case (addr_i)
                lftr_pkg::ADDR_ACOU2: rdata_r <= acou_r;
                lftr_pkg::ADDR_CFG6:  rdata_r <= cfg6_r;
                lftr_pkg::ADDR_CFG1:  rdata_r <= cfg1_r;
                lftr_pkg::ADDR_DUTY:  rdata_r <= duty_r;
                default:              rdata_r <= lftr_pkg::RD_UNMAPPED;
            endcase
        end
        else
            rdata_r <= lftr_pkg::RD_UNMAPPED;
    end

    assign code     = acou_r[lftr_pkg::CODE_MSB:lftr_pkg::CODE_LSB];
    assign inc      = code_to_inc(code);
    assign slow_sel = cfg6_r[lftr_pkg::CFG6_SLOW_BIT];
    assign quad_sel = cfg6_r[lftr_pkg::CFG6_LOCAL_BIT];

    // Slot length sets the full-ramp time; the increment shortens it per code
    assign base_per    = slow_sel ? 32'(SLOT_SLOW_CYC) : 32'(SLOT_FAST_CYC);
    assign slot.period = quad_sel ? 32'(base_per * lftr_pkg::SLOWDOWN) : base_per;

    lftr_slot_timer u_timer
    (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .slot      (slot)
    );

    // Other channels are outside this block, so they pass straight through
    always_comb
    begin
        duty_nxt = duty_r;
        if (!local_ctrl_i)
            duty_nxt = target_duty_i;
        else if (slot.tick)
            duty_nxt = step_toward(duty_r, target_duty_i, inc);
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
            duty_r <= lftr_pkg::RST_DUTY;
        else
            duty_r <= duty_nxt;
    end

    assign rd_data_o          = rdata_r;
    assign fan_drive_output_o = duty_r;

    // Checks

    sequence s_local_slot;
        local_ctrl_i && slot.tick;
    endsequence

    sequence s_local_idle;
        local_ctrl_i && !slot.tick;
    endsequence

    sequence s_locked_write;
        locked && wr_i && (addr_i == lftr_pkg::ADDR_ACOU2);
    endsequence

    a_lock_freeze : assert property (@(posedge sys_clk_i) disable iff (rst_i)
        s_locked_write |=> $stable(acou_r))
        else $error("ramp register changed while locked");

    a_lock_sticky : assert property (@(posedge sys_clk_i) disable iff (rst_i)
        locked |=> locked)
        else $error("lock bit cleared without reset");

    a_reset_zero : assert property (@(posedge sys_clk_i)
        rst_i |=> (acou_r == lftr_pkg::RST_ACOU2) && (rd_data_o == lftr_pkg::RD_UNMAPPED))
        else $error("ramp register not zero after reset");

    a_open_write : assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (!locked && wr_i && addr_i == lftr_pkg::ADDR_ACOU2)
        |=> acou_r == $past(wr_data_i))
        else $error("unlocked write to ramp register lost");

    a_quad_slot : assert property (@(posedge sys_clk_i) disable iff (rst_i)
        quad_sel |-> slot.period == 32'(base_per * lftr_pkg::SLOWDOWN))
        else $error("slowdown did not lengthen slot by four");

    a_fast_base : assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (!slow_sel && !quad_sel) |-> slot.period == 32'(SLOT_FAST_CYC))
        else $error("fast slot length wrong");

    a_slow_base : assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (slow_sel && !quad_sel) |-> slot.period == 32'(SLOT_SLOW_CYC))
        else $error("slow slot length wrong");

    a_inc_top : assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (code == 3'h7) |-> (inc == 8'h30))
        else $error("fastest code increment wrong");

    a_inc_mid : assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (code == 3'h5) |-> (inc == 8'h0C))
        else $error("code five increment wrong");

    a_hold_idle : assert property (@(posedge sys_clk_i) disable iff (rst_i)
        s_local_idle |=> $stable(fan_drive_output_o))
        else $error("duty moved between slots");

    a_step_bound : assert property (@(posedge sys_clk_i) disable iff (rst_i)
        s_local_slot |=>
        ((fan_drive_output_o >= $past(fan_drive_output_o)) ?
         (fan_drive_output_o - $past(fan_drive_output_o)) <= $past(inc) :
         ($past(fan_drive_output_o) - fan_drive_output_o) <= $past(inc)))
        else $error("duty stepped further than one increment");

    a_reach_hold : assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (s_local_slot ##0 (duty_r == target_duty_i)) |=> $stable(fan_drive_output_o))
        else $error("duty left its target");

    a_step_taken : assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (s_local_slot ##0 (duty_r != target_duty_i)) |=> !$stable(fan_drive_output_o))
        else $error("duty did not move on a slot");

    a_no_overshoot : assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (s_local_slot ##0 (target_duty_i >= duty_r))
        |=> fan_drive_output_o <= $past(target_duty_i))
        else $error("duty passed its target");

    a_follow_direct : assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !local_ctrl_i |=> fan_drive_output_o == $past(target_duty_i))
        else $error("duty did not follow target outside local control");

    a_cfg_frozen : assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (locked && wr_i && addr_i == lftr_pkg::ADDR_CFG6) |=> $stable(cfg6_r))
        else $error("config six changed while locked");

    a_inc_low : assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (code == 3'h0) |-> (inc == 8'h01))
        else $error("slowest code increment wrong");

    a_inc_four : assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (code == 3'h3) |-> (inc == 8'h04))
        else $error("code three increment wrong");

    a_read_ramp : assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (rd_i && addr_i == lftr_pkg::ADDR_ACOU2) |=> rd_data_o == $past(acou_r))
        else $error("ramp register read wrong");

    a_read_duty : assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (rd_i && addr_i == lftr_pkg::ADDR_DUTY) |=> rd_data_o == $past(duty_r))
        else $error("duty status read wrong");

    a_read_idle : assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !rd_i |=> rd_data_o == lftr_pkg::RD_UNMAPPED)
        else $error("read data stood past its cycle");

    a_duty_reset : assert property (@(posedge sys_clk_i)
        rst_i |=> fan_drive_output_o == lftr_pkg::RST_DUTY)
        else $error("duty not zero after reset");

    // Slot length is checked against a count kept outside the timer
    logic [31:0] gap_cnt_r;
    logic [31:0] per_last_r;
    logic        per_moved_r;

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
            gap_cnt_r <= '0;
        else if (slot.tick)
            gap_cnt_r <= 32'h00000001;
        else
            gap_cnt_r <= gap_cnt_r + 32'h00000001;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
            per_last_r <= '0;
        else
            per_last_r <= slot.period;
    end

    // A period change mid-slot makes that one slot irregular, so it is skipped
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
            per_moved_r <= 1'b1;
        else if (slot.period != per_last_r)
            per_moved_r <= 1'b1;
        else if (slot.tick)
            per_moved_r <= 1'b0;
    end

    a_slot_length : assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (slot.tick && !per_moved_r && slot.period == per_last_r)
        |-> gap_cnt_r == slot.period)
        else $error("time slot length differs from its period");

endmodule // lftr_top
`default_nettype wire

//--- dv/lftr_top_tb_top.sv
// Self-checking bench for the local fan ramp limiter
`timescale 1ns/100ps
`default_nettype none
module lftr_top_tb_top;
    // Short slots keep the run brief
    localparam int unsigned P_FAST = 40;
    localparam int unsigned P_SLOW = 56;
    localparam int          INC[8] = '{1, 2, 3, 4, 8, 12, 24, 48};
    logic        sys_clk_i;
    logic        rst_i;
    logic [7:0]  addr_i;
    logic [7:0]  wr_data_i;
    logic        wr_i;
    logic        rd_i;
    logic [7:0]  rd_data_o;
    logic        local_ctrl_i;
    logic [7:0]  target_duty_i;
    logic [7:0]  fan_drive_output_o;
    logic [7:0]  exp_q[$];
    string       nm_q[$];
    logic        rd_pend = 1'b0;
    int          n_fail = 0;
    int          comparisons = 0;
    int          cyc = 0;
    logic [31:0] lfsr = 32'h000004F9;
    logic [7:0]  r;
    int          c;

    lftr_top #(.SLOT_FAST_CYC(P_FAST), .SLOT_SLOW_CYC(P_SLOW)) lftr_top_inst
    (
        .sys_clk_i          (sys_clk_i),
        .rst_i              (rst_i),
        .addr_i             (addr_i),
        .wr_data_i          (wr_data_i),
        .wr_i               (wr_i),
        .rd_i               (rd_i),
        .rd_data_o          (rd_data_o),
        .local_ctrl_i       (local_ctrl_i),
        .target_duty_i      (target_duty_i),
        .fan_drive_output_o (fan_drive_output_o)
    );

    initial
    begin
        sys_clk_i = 1'b0;
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end

    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Read data stand only in the cycle after the strobe
    always @(posedge sys_clk_i)
    begin
        if (rd_pend && exp_q.size() > 0)
            check(nm_q.pop_front(), rd_data_o, exp_q.pop_front());
        rd_pend <= rd_i;
    end

    always @(posedge sys_clk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_fail++;
            wrap_up();
        end
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic rnd;
        lfsr = lfsr_next(lfsr);
        r = lfsr[7:0];
    endtask

    // One idle cycle after each access avoids re-driving a strobe in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr_i    <= a;
        wr_data_i <= d;
        wr_i      <= 1'b1;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
        @(posedge sys_clk_i);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
        exp_q.push_back(e);
        nm_q.push_back(nm);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        @(posedge sys_clk_i);
    endtask

    task automatic do_reset;
        rst_i         <= 1'b1;
        local_ctrl_i  <= 1'b0;
        target_duty_i <= 8'h00;
        repeat (3) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        @(posedge sys_clk_i);
    endtask

    // Slot timer restarts at reset, so reads sit mid-slot to absorb edge offsets
    task automatic ramp(input logic [7:0] cfg6, input int code, input logic [7:0] tg);
        int p;
        int t;
        int e;
        p = cfg6[7] ? P_SLOW : P_FAST;
        if (cfg6[2])
            p = p * 4;
        do_reset();
        wr(lftr_pkg::ADDR_CFG6, cfg6);
        wr(lftr_pkg::ADDR_ACOU2, code[7:0]);
        local_ctrl_i  <= 1'b1;
        target_duty_i <= tg;
        t = 4;
        for (int k = 0; k < 4; k++)
        begin
            repeat (k * p + p / 2 - t) @(posedge sys_clk_i);
            e = k * INC[code];
            rd(lftr_pkg::ADDR_DUTY, (e > int'(tg)) ? tg : e[7:0], "duty");
            t = k * p + p / 2 + 2;
        end
    endtask

    initial
    begin
        rst_i         = 1'b1;
        addr_i        = 8'h00;
        wr_data_i     = 8'h00;
        wr_i          = 1'b0;
        rd_i          = 1'b0;
        local_ctrl_i  = 1'b0;
        target_duty_i = 8'h00;
        do_reset();
        rd(lftr_pkg::ADDR_ACOU2, 8'h00, "ramp reg reset");
        rd(lftr_pkg::ADDR_DUTY, 8'h00, "duty reset");
        rd(8'h7E, 8'h00, "unmapped");
        rnd();
        wr(lftr_pkg::ADDR_ACOU2, r);
        rd(lftr_pkg::ADDR_ACOU2, r, "ramp reg rw");
        target_duty_i <= ~r;
        repeat (2) @(posedge sys_clk_i);
        rd(lftr_pkg::ADDR_DUTY, ~r, "duty follow");
        wr(lftr_pkg::ADDR_CFG1, 8'h02);
        wr(lftr_pkg::ADDR_ACOU2, ~r);
        rd(lftr_pkg::ADDR_ACOU2, r, "ramp reg locked");
        wr(lftr_pkg::ADDR_CFG1, 8'h00);
        rd(lftr_pkg::ADDR_CFG1, 8'h02, "lock sticky");
        wr(lftr_pkg::ADDR_CFG6, 8'h84);
        rd(lftr_pkg::ADDR_CFG6, 8'h00, "cfg6 locked");
        for (c = 0; c < 8; c++)
        begin
            rnd();
            ramp(8'h00, c, (c == 7) ? 8'h64 : (r | 8'h80));
        end
        ramp(8'h80, 3, 8'hF0);
        ramp(8'h04, 3, 8'hF0);
        ramp(8'h84, 5, 8'hF0);
        wrap_up();
    end
endmodule // lftr_top_tb_top
`default_nettype wire
